// ### src/msdec_defs.vh
// Offsets, fields, codes and reset values of the search control decoder
`ifndef MSDEC_DEFS_VH
`define MSDEC_DEFS_VH
// ****************************************************************
// Register byte addresses
// ****************************************************************
`define MSDEC_A_CTRL      8'h00
`define MSDEC_A_MSGTYPE   8'h04
`define MSDEC_A_PARAM     8'h08
`define MSDEC_A_STATUS    8'h0c
`define MSDEC_A_DECODE    8'h10
`define MSDEC_A_RESULT    8'h14
// ****************************************************************
// Control dword fields
// ****************************************************************
`define MSDEC_SEL_HI      10
`define MSDEC_SEL_LO      8
`define MSDEC_REF_BIT     7
`define MSDEC_SRC_BIT     6
`define MSDEC_REMAP_HI    5
`define MSDEC_REMAP_LO    4
// ****************************************************************
// Parameter register fields
// ****************************************************************
`define MSDEC_P_ADAPT     0
`define MSDEC_P_FRAC      1
`define MSDEC_P_STEP_HI   15
`define MSDEC_P_STEP_LO   8
`define MSDEC_P_MASK_HI   19
`define MSDEC_P_MASK_LO   16
// ****************************************************************
// Status register fields
// ****************************************************************
`define MSDEC_S_BUSY      0
`define MSDEC_S_ERR_SEL   4
`define MSDEC_S_ERR_STEP  5
`define MSDEC_S_ERR_RMAP  6
`define MSDEC_S_REFUSED   7
// ****************************************************************
// Codes
// ****************************************************************
`define MSDEC_SEL_SINGLE  3'h0
`define MSDEC_SEL_DSTART  3'h1
`define MSDEC_SEL_DREC    3'h3
`define MSDEC_SEL_DREF    3'h7
`define MSDEC_RMAP_NONE   2'h0
`define MSDEC_RMAP_FWD    2'h1
`define MSDEC_RMAP_BWD    2'h2
`define MSDEC_RMAP_RSVD   2'h3
`define MSDEC_MSG_IME     2'h0
`define MSDEC_MSG_SIC     2'h1
`define MSDEC_MSG_FBR     2'h2
`define MSDEC_MSG_IDM     2'h3
`define MSDEC_MASK_ALL    4'hf
`define MSDEC_MIN_STEP    8'h02
// ****************************************************************
// Reset values
// ****************************************************************
`define MSDEC_RST_PARAM   32'h00000000
`define MSDEC_RST_MSG     2'h0
`endif

// ### src/msdec_mode_decode.v
// Search selector decoder: references, records, starts, cost centres
`timescale 1ns/10ps
`include "msdec_defs.vh"
module msdec_mode_decode (
	// Selector in
	input  wire [2:0] sel,
	// Decoded mode
	output reg        ref1_en,
	output reg        dual_record,
	output reg        dual_start,
	output reg        cost1_en,
	output reg        start1_path,
	output reg        merge_first,
	output reg        per_record,
	output reg        reserved
);
	always @* begin
		ref1_en     = 1'b0;
		dual_record = 1'b0;
		dual_start  = 1'b0;
		cost1_en    = 1'b0;
		start1_path = 1'b0;
		merge_first = 1'b0;
		per_record  = 1'b0;
		reserved    = 1'b0;
		case (sel)
		`MSDEC_SEL_SINGLE: begin
			reserved = 1'b0;
		end
		`MSDEC_SEL_DSTART: begin
			dual_start  = 1'b1;
			start1_path = 1'b1;
		end
		`MSDEC_SEL_DREC: begin
			dual_start  = 1'b1;
			dual_record = 1'b1;
			cost1_en    = 1'b1;
			merge_first = 1'b1;
		end
		`MSDEC_SEL_DREF: begin
			ref1_en     = 1'b1;
			dual_start  = 1'b1;
			dual_record = 1'b1;
			cost1_en    = 1'b1;
			per_record  = 1'b1;
		end
		default: begin
			reserved = 1'b1;
		end
		endcase
	end
endmodule

// ### src/msdec_remap.v
// Inter block type remapping for search results
`timescale 1ns/10ps
`include "msdec_defs.vh"
module msdec_remap (
	// Result in
	input  wire [5:0] type_in,
	input  wire       intra,
	input  wire [1:0] mode,
	// Result out
	output reg  [5:0] type_out
);
	wire lo_grp;
	wire mid_grp;
	assign lo_grp  = (type_in >= 6'h01) && (type_in <= 6'h03);
	assign mid_grp = (type_in >= 6'h04) && (type_in <= 6'h15);

	always @* begin
		type_out = type_in;
		// Intra results keep their type whatever the mode
		if (!intra) begin
			case (mode)
			`MSDEC_RMAP_FWD: begin
				if (lo_grp)
					type_out = 6'h01;
				else if (mid_grp)
					type_out = type_in[0] ? 6'h05 : 6'h04;
			end
			`MSDEC_RMAP_BWD: begin
				if (lo_grp)
					type_out = 6'h02;
				else if (mid_grp)
					type_out = type_in[0] ? 6'h07 : 6'h06;
			end
			default: begin
				type_out = type_in;
			end
			endcase
		end
	end
endmodule

// ### src/msdec_top.v
// Motion search control dword decoder with AHB-Lite register slave
`timescale 1ns/10ps
`include "msdec_defs.vh"
// Contract
// - Code 000b searches reference 0, cost centre 0, start 0, one record.
// - Code 001b visits start 0 then start 1, one record, then path.
// - Code 011b uses both starts, centres, two records merged before refine.
// - Code 111b searches both references, refines per record, combines.
// - Dual reference with all-ones partition mask skips bidir estimation.
// - Bidir estimation and sub-pel refine are enabled independently.
// - Reference access bit 7 selects frame or field reference fetch.
// - Source access bit 6 selects frame or field source fetch.
// - Block type remap applies to inter results only, never intra.
// - Remap 01b maps types to forward-only codes 1, 4, 5.
// - Remap 10b maps types to backward-only codes 2, 6, 7.
// - Remap 00b passes type through; 11b is reserved.
// - Fields not valid for the message type are ignored.
module msdec_top (
	// Clock and reset
	input  wire        CLK,
	input  wire        RST,
	// AHB-Lite slave
	input  wire        HSEL,
	input  wire [7:0]  HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output wire        HREADYOUT,
	output wire        HRESP,
	output wire [31:0] HRDATA,
	// Request to the search engine
	output wire        REQ_START,
	output wire        REQ_ACTIVE,
	output wire        REF1_EN,
	output wire        DUAL_RECORD,
	output wire        DUAL_START,
	output wire        COST1_EN,
	output wire        START1_PATH,
	output wire        MERGE_FIRST,
	output wire        PER_RECORD,
	output wire        BIDIR_EST_EN,
	output wire        FRAC_REFINE_EN,
	output wire        ADAPT_EN,
	output wire [7:0]  ADAPT_STEPS,
	output wire        REF_FIELD,
	output wire        SRC_FIELD,
	input  wire        ENG_DONE,
	// Result from the engine
	input  wire        RES_VALID,
	input  wire [5:0]  RES_TYPE,
	input  wire        RES_INTRA,
	output wire        OUT_VALID,
	output wire [5:0]  OUT_TYPE,
	output wire        OUT_INTRA
);
// ****************************************************************
// State codes
// ****************************************************************
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_BUSY = 2'b10;

	reg  [1:0]  state_ff;
	reg  [1:0]  nxt_state;
	reg         wr_ff;
	reg         rd_ff;
	reg  [7:0]  addr_ff;
	reg  [31:0] rdata_ff;
	reg  [31:0] nxt_rdata;
	reg  [31:0] param_ff;
	reg  [1:0]  msg_ff;
	reg  [2:0]  sel_ff;
	reg         ref_field_ff;
	reg         src_field_ff;
	reg  [1:0]  remap_ff;
	reg         ref1_ff;
	reg         drec_ff;
	reg         dstart_ff;
	reg         cost1_ff;
	reg         s1path_ff;
	reg         merge_ff;
	reg         perrec_ff;
	reg         bidir_ff;
	reg         frac_ff;
	reg         adapt_ff;
	reg  [7:0]  steps_ff;
	reg         start_ff;
	reg         err_sel_ff;
	reg         err_step_ff;
	reg         err_rmap_ff;
	reg         refused_ff;
	reg         out_valid_ff;
	reg  [5:0]  out_type_ff;
	reg         out_intra_ff;

	wire        addr_phase;
	wire        wr_do;
	wire        ctrl_wr;
	wire        stat_wr;
	wire        accept;
	wire        refuse;
	wire        is_ime;
	wire        remap_ok;
	wire [2:0]  eff_sel;
	wire [1:0]  eff_remap;
	wire        d_ref1;
	wire        d_drec;
	wire        d_dstart;
	wire        d_cost1;
	wire        d_s1path;
	wire        d_merge;
	wire        d_perrec;
	wire        d_rsvd;
	wire        step_low;
	wire [5:0]  mapped;

// ****************************************************************
// Bus slave
// ****************************************************************
	// Every access completes with no wait state and OKAY
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign HRDATA    = rdata_ff;
	assign addr_phase = HSEL && HTRANS[1] && HREADY;
	assign wr_do      = wr_ff && HREADY;

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_ff   <= 1'b0;
			rd_ff   <= 1'b0;
			addr_ff <= 8'h00;
		end else if (HREADY) begin
			wr_ff   <= addr_phase && HWRITE;
			rd_ff   <= addr_phase && !HWRITE;
			addr_ff <= HADDR;
		end
	end

	// Read data is fetched in the address phase so it stands from a flop
	always @* begin
		nxt_rdata = 32'h00000000;
		case (HADDR)
		`MSDEC_A_CTRL: begin
			nxt_rdata[`MSDEC_SEL_HI:`MSDEC_SEL_LO] = sel_ff;
			nxt_rdata[`MSDEC_REF_BIT] = ref_field_ff;
			nxt_rdata[`MSDEC_SRC_BIT] = src_field_ff;
			nxt_rdata[`MSDEC_REMAP_HI:`MSDEC_REMAP_LO] = remap_ff;
		end
		`MSDEC_A_MSGTYPE: begin
			nxt_rdata[1:0] = msg_ff;
		end
		`MSDEC_A_PARAM: begin
			nxt_rdata = param_ff;
		end
		`MSDEC_A_STATUS: begin
			nxt_rdata[`MSDEC_S_BUSY]     = state_ff[1];
			nxt_rdata[`MSDEC_S_ERR_SEL]  = err_sel_ff;
			nxt_rdata[`MSDEC_S_ERR_STEP] = err_step_ff;
			nxt_rdata[`MSDEC_S_ERR_RMAP] = err_rmap_ff;
			nxt_rdata[`MSDEC_S_REFUSED]  = refused_ff;
		end
		`MSDEC_A_DECODE: begin
			nxt_rdata[9:0] = {frac_ff, bidir_ff, perrec_ff, merge_ff,
				s1path_ff, cost1_ff, dstart_ff, drec_ff, ref1_ff, adapt_ff};
		end
		`MSDEC_A_RESULT: begin
			nxt_rdata[7:0] = {out_intra_ff, 1'b0, out_type_ff};
		end
		default: begin
			nxt_rdata = 32'h00000000;
		end
		endcase
	end

	always @(posedge CLK or posedge RST) begin
		if (RST)
			rdata_ff <= 32'h00000000;
		else if (addr_phase && !HWRITE)
			rdata_ff <= nxt_rdata;
	end

// ****************************************************************
// Message decode
// ****************************************************************
	assign ctrl_wr = wr_do && (addr_ff == `MSDEC_A_CTRL);
	assign stat_wr = wr_do && (addr_ff == `MSDEC_A_STATUS);
	assign is_ime  = (msg_ff == `MSDEC_MSG_IME);
	// Selector only counts for integer search requests
	assign eff_sel = is_ime ? HWDATA[`MSDEC_SEL_HI:`MSDEC_SEL_LO]
		: `MSDEC_SEL_SINGLE;
	assign remap_ok = is_ime || (msg_ff == `MSDEC_MSG_FBR);
	assign eff_remap = remap_ok ? HWDATA[`MSDEC_REMAP_HI:`MSDEC_REMAP_LO]
		: `MSDEC_RMAP_NONE;
	// Reserved selector codes never reach the engine
	assign refuse = ctrl_wr && (state_ff[1] || d_rsvd);
	assign accept = ctrl_wr && state_ff[0] && !d_rsvd;
	assign step_low = (eff_sel == `MSDEC_SEL_SINGLE)
		&& param_ff[`MSDEC_P_ADAPT]
		&& (param_ff[`MSDEC_P_STEP_HI:`MSDEC_P_STEP_LO] < `MSDEC_MIN_STEP);

	msdec_mode_decode u_mode (
		.sel         (eff_sel),
		.ref1_en     (d_ref1),
		.dual_record (d_drec),
		.dual_start  (d_dstart),
		.cost1_en    (d_cost1),
		.start1_path (d_s1path),
		.merge_first (d_merge),
		.per_record  (d_perrec),
		.reserved    (d_rsvd)
	);

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			param_ff <= `MSDEC_RST_PARAM;
			msg_ff   <= `MSDEC_RST_MSG;
		end else if (wr_do && state_ff[0]) begin
			// Held while busy so the live request cannot shift
			if (addr_ff == `MSDEC_A_PARAM)
				param_ff <= HWDATA;
			if (addr_ff == `MSDEC_A_MSGTYPE)
				msg_ff <= HWDATA[1:0];
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			sel_ff       <= `MSDEC_SEL_SINGLE;
			ref_field_ff <= 1'b0;
			src_field_ff <= 1'b0;
			remap_ff     <= `MSDEC_RMAP_NONE;
			ref1_ff      <= 1'b0;
			drec_ff      <= 1'b0;
			dstart_ff    <= 1'b0;
			cost1_ff     <= 1'b0;
			s1path_ff    <= 1'b0;
			merge_ff     <= 1'b0;
			perrec_ff    <= 1'b0;
			bidir_ff     <= 1'b0;
			frac_ff      <= 1'b0;
			adapt_ff     <= 1'b0;
			steps_ff     <= 8'h00;
		end else if (accept) begin
			sel_ff       <= eff_sel;
			ref_field_ff <= HWDATA[`MSDEC_REF_BIT];
			src_field_ff <= HWDATA[`MSDEC_SRC_BIT];
			remap_ff     <= eff_remap;
			ref1_ff      <= d_ref1;
			drec_ff      <= d_drec;
			dstart_ff    <= d_dstart;
			cost1_ff     <= d_cost1;
			s1path_ff    <= d_s1path;
			merge_ff     <= d_merge;
			perrec_ff    <= d_perrec;
			// Mask all ones means unidirectional results only
			bidir_ff     <= d_ref1 && (param_ff[`MSDEC_P_MASK_HI:
				`MSDEC_P_MASK_LO] != `MSDEC_MASK_ALL);
			// Sub-pel refine does not look at bidir at all
			frac_ff      <= param_ff[`MSDEC_P_FRAC];
			adapt_ff     <= param_ff[`MSDEC_P_ADAPT];
			steps_ff     <= param_ff[`MSDEC_P_STEP_HI:`MSDEC_P_STEP_LO];
		end
	end

// ****************************************************************
// Request sequencing
// ****************************************************************
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		ST_IDLE: begin
			if (accept)
				nxt_state = ST_BUSY;
		end
		ST_BUSY: begin
			if (ENG_DONE)
				nxt_state = ST_IDLE;
		end
		default: begin
			nxt_state = ST_IDLE;
		end
		endcase
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_ff <= ST_IDLE;
			start_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_ff <= accept;
		end
	end

// ****************************************************************
// Sticky status, write one to clear, a new event wins
// ****************************************************************
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			err_sel_ff  <= 1'b0;
			err_step_ff <= 1'b0;
			err_rmap_ff <= 1'b0;
			refused_ff  <= 1'b0;
		end else begin
			err_sel_ff <= (ctrl_wr && d_rsvd)
				|| (err_sel_ff && !(stat_wr && HWDATA[`MSDEC_S_ERR_SEL]));
			// The engine lags one step, so a short count is flagged
			err_step_ff <= (accept && step_low)
				|| (err_step_ff
				&& !(stat_wr && HWDATA[`MSDEC_S_ERR_STEP]));
			err_rmap_ff <= (accept && (eff_remap == `MSDEC_RMAP_RSVD))
				|| (err_rmap_ff
				&& !(stat_wr && HWDATA[`MSDEC_S_ERR_RMAP]));
			refused_ff <= refuse
				|| (refused_ff && !(stat_wr && HWDATA[`MSDEC_S_REFUSED]));
		end
	end

// ****************************************************************
// Result remapping
// ****************************************************************
	msdec_remap u_remap (
		.type_in  (RES_TYPE),
		.intra    (RES_INTRA),
		.mode     (remap_ff),
		.type_out (mapped)
	);

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			out_valid_ff <= 1'b0;
			out_type_ff  <= 6'h00;
			out_intra_ff <= 1'b0;
		end else begin
			out_valid_ff <= RES_VALID;
			if (RES_VALID) begin
				out_type_ff  <= mapped;
				out_intra_ff <= RES_INTRA;
			end
		end
	end

// ****************************************************************
// Outputs
// ****************************************************************
	assign REQ_START      = start_ff;
	assign REQ_ACTIVE     = state_ff[1];
	assign REF1_EN        = ref1_ff;
	assign DUAL_RECORD    = drec_ff;
	assign DUAL_START     = dstart_ff;
	assign COST1_EN       = cost1_ff;
	assign START1_PATH    = s1path_ff;
	assign MERGE_FIRST    = merge_ff;
	assign PER_RECORD     = perrec_ff;
	assign BIDIR_EST_EN   = bidir_ff;
	assign FRAC_REFINE_EN = frac_ff;
	assign ADAPT_EN       = adapt_ff;
	assign ADAPT_STEPS    = steps_ff;
	assign REF_FIELD      = ref_field_ff;
	assign SRC_FIELD      = src_field_ff;
	assign OUT_VALID      = out_valid_ff;
	assign OUT_TYPE       = out_type_ff;
	assign OUT_INTRA      = out_intra_ff;
endmodule

// ### verification/msdec_checker.sv
// Port assertions for the search control decoder
`timescale 1ns/10ps
module msdec_checker (
	// Clock and reset
	input wire       CLK,
	input wire       RST,
	// Request
	input wire       REQ_START,
	input wire       REQ_ACTIVE,
	input wire       ENG_DONE,
	input wire       REF1_EN,
	input wire       DUAL_RECORD,
	input wire       DUAL_START,
	input wire       COST1_EN,
	input wire       PER_RECORD,
	input wire       BIDIR_EST_EN,
	// Result
	input wire       RES_VALID,
	input wire [5:0] RES_TYPE,
	input wire       RES_INTRA,
	input wire       OUT_VALID,
	input wire [5:0] OUT_TYPE,
	input wire       OUT_INTRA
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_pulse; REQ_START |=> !REQ_START; endproperty
	a_pulse: assert property (p_pulse)
		else $error("start pulse too long");
	property p_active; REQ_START |-> REQ_ACTIVE; endproperty
	a_active: assert property (p_active)
		else $error("start without active");
	property p_done; REQ_ACTIVE && ENG_DONE |=> !REQ_ACTIVE; endproperty
	a_done: assert property (p_done)
		else $error("active after done");
	// Decode must not move under a running search
	property p_hold;
		REQ_ACTIVE && !REQ_START |-> $stable({REF1_EN, DUAL_RECORD,
			DUAL_START, COST1_EN, PER_RECORD, BIDIR_EST_EN});
	endproperty
	a_hold: assert property (p_hold)
		else $error("decode changed while active");
	property p_sel;
		REQ_START |-> REF1_EN == PER_RECORD && DUAL_RECORD == COST1_EN
			&& (DUAL_START || !DUAL_RECORD);
	endproperty
	a_sel: assert property (p_sel)
		else $error("inconsistent mode decode");
	property p_bidir; BIDIR_EST_EN |-> REF1_EN; endproperty
	a_bidir: assert property (p_bidir)
		else $error("bidir without dual reference");
	property p_res; 1'b1 |=> OUT_VALID == $past(RES_VALID); endproperty
	a_res: assert property (p_res)
		else $error("result strobe mismatch");
	property p_intra;
		RES_VALID && RES_INTRA |=> OUT_INTRA && OUT_TYPE == $past(RES_TYPE);
	endproperty
	a_intra: assert property (p_intra)
		else $error("intra result remapped");
	property p_t16; RES_VALID && RES_TYPE == 6'h16 |=> OUT_TYPE == 6'h16;
	endproperty
	a_t16: assert property (p_t16)
		else $error("type 16h changed");
	c_dref: cover property (REQ_START && PER_RECORD);
	c_bidir: cover property (BIDIR_EST_EN);
	c_intra: cover property (RES_VALID && RES_INTRA);
endmodule
bind msdec_top msdec_checker u_chk (.CLK, .RST, .REQ_START, .REQ_ACTIVE,
	.ENG_DONE, .REF1_EN, .DUAL_RECORD, .DUAL_START, .COST1_EN, .PER_RECORD,
	.BIDIR_EST_EN, .RES_VALID, .RES_TYPE, .RES_INTRA, .OUT_VALID,
	.OUT_TYPE, .OUT_INTRA);

// ### verification/msdec_host.sv
// Bus master model of the requesting thread
`timescale 1ns/10ps
module msdec_host (
	// Clock
	input  wire        clk,
	// AHB-Lite master
	output reg         hsel,
	output reg  [7:0]  haddr,
	output reg  [1:0]  htrans,
	output reg         hwrite,
	output reg  [2:0]  hsize,
	output reg  [31:0] hwdata,
	input  wire        hready,
	input  wire [31:0] hrdata
);
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// Released lines show the inverse so stale values never match
	task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		begin
			@(posedge clk);
			hsel <= 1'b1;
			haddr <= a;
			htrans <= 2'h2;
			hwrite <= w;
			@(posedge clk);
			while (!hready) @(posedge clk);
			hsel <= 1'b0;
			htrans <= 2'h0;
			haddr <= ~a;
			hwdata <= d;
			@(posedge clk);
			while (!hready) @(posedge clk);
			q = hrdata;
			hwdata <= ~d;
		end
	endtask
endmodule

// ### verification/tb_msdec_top.sv
// Self-checking bench for the search control decoder
`timescale 1ns/10ps
`include "msdec_defs.vh"
module tb_msdec_top;
	reg         CLK, RST, ENG_DONE, RES_VALID, RES_INTRA;
	reg  [5:0]  RES_TYPE;
	wire        HSEL, HWRITE, HREADYOUT, HRESP, REQ_START, REQ_ACTIVE;
	wire        REF1_EN, DUAL_RECORD, DUAL_START, COST1_EN, START1_PATH;
	wire        MERGE_FIRST, PER_RECORD, BIDIR_EST_EN, FRAC_REFINE_EN;
	wire        ADAPT_EN, REF_FIELD, SRC_FIELD, OUT_VALID, OUT_INTRA;
	wire [7:0]  HADDR, ADAPT_STEPS;
	wire [1:0]  HTRANS;
	wire [2:0]  HSIZE;
	wire [31:0] HWDATA, HRDATA;
	wire [5:0]  OUT_TYPE;
	wire [10:0] dv = {REF1_EN, DUAL_RECORD, DUAL_START, COST1_EN,
		START1_PATH, MERGE_FIRST, PER_RECORD, BIDIR_EST_EN,
		FRAC_REFINE_EN, REF_FIELD, SRC_FIELD};
	localparam [53:0] TT = {6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h12,
		6'h14, 6'h15, 6'h16};
	integer     n_errors, comparisons, cycles, i, j, k;
	reg  [31:0] q;
	reg  [10:0] e;
	reg  [5:0]  t;
	reg  [2:0]  s;
	msdec_top u_dut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
		.HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA,
		.REQ_START, .REQ_ACTIVE, .REF1_EN, .DUAL_RECORD, .DUAL_START,
		.COST1_EN, .START1_PATH, .MERGE_FIRST, .PER_RECORD, .BIDIR_EST_EN,
		.FRAC_REFINE_EN, .ADAPT_EN, .ADAPT_STEPS, .REF_FIELD, .SRC_FIELD,
		.ENG_DONE, .RES_VALID, .RES_TYPE, .RES_INTRA, .OUT_VALID,
		.OUT_TYPE, .OUT_INTRA);
	msdec_host u_host (.clk(CLK), .hsel(HSEL), .haddr(HADDR),
		.htrans(HTRANS), .hwrite(HWRITE), .hsize(HSIZE), .hwdata(HWDATA),
		.hready(HREADYOUT), .hrdata(HRDATA));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function [5:0] er(input [1:0] c, input [5:0] v, input x);
		if (x || c == 2'h0 || c == 2'h3 || v == 6'h0 || v > 6'h15)
			er = v;
		else if (v < 6'h4)
			er = c[0] ? 6'h1 : 6'h2;
		else if (!v[0])
			er = c[0] ? 6'h4 : 6'h6;
		else
			er = c[0] ? 6'h5 : 6'h7;
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		u_host.xfer(1'b1, a, d, q);
	endtask
	task rd(input [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, q);
	endtask
	task done;
		begin
			@(posedge CLK) ENG_DONE <= 1'b1;
			@(posedge CLK) ENG_DONE <= 1'b0;
			#1 chk(REQ_ACTIVE, 1'b0);
		end
	endtask
	task res(input [5:0] v, input x, input [5:0] ex);
		begin
			@(posedge CLK) begin
				RES_VALID <= 1'b1;
				RES_TYPE <= v;
				RES_INTRA <= x;
			end
			@(posedge CLK) RES_VALID <= 1'b0;
			#1 chk({OUT_VALID, OUT_INTRA, OUT_TYPE}, {1'b1, x, ex});
		end
	endtask
	task final_report;
		begin
			$display("errors=%0d comparisons=%0d", n_errors, comparisons);
			if (n_errors == 0 && comparisons > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	initial cycles = 0;
	// Hang guard well above the few hundred cycles used
	always @(posedge CLK) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			final_report;
		end
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		{RST, ENG_DONE, RES_VALID, RES_INTRA, RES_TYPE} = 10'h200;
		n_errors = 0;
		comparisons = 0;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		rd(`MSDEC_A_PARAM);
		chk(q, `MSDEC_RST_PARAM);
		rd(8'h20);
		chk(q, 32'h0);
		chk({HREADYOUT, HRESP}, 2'h2);
		// Codes, mask and field bits; bits 7 and 6 differ in half the passes to catch a swap
		for (i = 0; i < 8; i = i + 1) begin
			s = {i[1] & i[0], i[1], i[1] | i[0]};
			e = {s == 3'h7, s[1], s[0], s[1], s == 3'h1, s == 3'h3,
				s == 3'h7, s == 3'h7 && !i[2], i[0], i[1], i[2] ^ i[0]};
			wr(`MSDEC_A_MSGTYPE, 32'h0);
			wr(`MSDEC_A_PARAM, {12'h0, i[2] ? 4'hf : 4'h5,
				i == 0 ? 8'h01 : 8'h02, 6'h0, i[0], 1'b1});
			wr(`MSDEC_A_CTRL, {21'h0, s, e[1], e[0], 6'h0});
			#1 chk(REQ_START, 1'b1);
			chk(dv, e);
			chk({ADAPT_EN, ADAPT_STEPS},
				{1'b1, i == 0 ? 8'h01 : 8'h02});
			rd(`MSDEC_A_CTRL);
			chk(q, {21'h0, s, e[1], e[0], 6'h0});
			wr(`MSDEC_A_CTRL, 32'h0);
			chk(dv, e);
			rd(`MSDEC_A_STATUS);
			chk(q & 32'hb1, i == 0 ? 32'ha1 : 32'h81);
			rd(`MSDEC_A_DECODE);
			chk(q, {22'h0, e[2], e[3], e[4], e[5], e[6], e[7], e[8],
				e[9], e[10], 1'b1});
			wr(`MSDEC_A_STATUS, 32'hf0);
			done;
		end
		for (j = 0; j < 4; j = j + 1) begin
			s = j == 0 ? 3'h2 : j + 3;
			wr(`MSDEC_A_CTRL, {21'h0, s, 8'h0});
			#1 chk(REQ_START, 1'b0);
			rd(`MSDEC_A_STATUS);
			chk(q & 32'h10, 32'h10);
			wr(`MSDEC_A_STATUS, 32'hf0);
		end
		// Other messages: selector ignored, remap kept only for refine
		for (k = 1; k < 4; k = k + 1) begin
			wr(`MSDEC_A_MSGTYPE, k);
			rd(`MSDEC_A_MSGTYPE);
			chk(q, k);
			wr(`MSDEC_A_CTRL, 32'h720);
			#1 chk({REQ_START, REF1_EN, DUAL_RECORD}, 3'h4);
			done;
			res(6'h05, 1'b0, k == 2 ? 6'h07 : 6'h05);
		end
		wr(`MSDEC_A_MSGTYPE, 32'h0);
		for (j = 0; j < 4; j = j + 1) begin
			wr(`MSDEC_A_CTRL, {26'h0, j[1:0], 4'h0});
			rd(`MSDEC_A_STATUS);
			chk(q & 32'h40, j == 3 ? 32'h40 : 32'h0);
			done;
			for (k = 0; k < 9; k = k + 1) begin
				t = TT[k * 6 +: 6];
				res(t, 1'b0, er(j[1:0], t, 1'b0));
			end
			res(6'h04, 1'b1, 6'h04);
			rd(`MSDEC_A_RESULT);
			chk(q, 32'h84);
		end
		final_report;
	end
endmodule
